// file: emb_bus_map.vh
// constants for the external memory bus port: counts, slots and reset values
// assumes one oscillator clock; one machine cycle is 12 oscillator periods
`ifndef EMB_BUS_MAP_VH
`define EMB_BUS_MAP_VH

// machine cycle: 6 states of 2 oscillator periods each
`define EMB_STATE_LAST 3'h5
`define EMB_C_LAST 4'hB

// address latch strobe windows
`define EMB_ALE_A0 4'h0
`define EMB_ALE_A1 4'h1
`define EMB_ALE_B0 4'h6
`define EMB_ALE_B1 4'h7

// program fetch strobe low slots, one every three periods
`define EMB_PFS_0 4'h2
`define EMB_PFS_1 4'h5
`define EMB_PFS_2 4'h8
`define EMB_PFS_3 4'hB

// fetched byte capture point (synchroniser delay of two)
`define EMB_FETCH_CAP 4'h7

// external data move windows
`define EMB_STB_FIRST 4'h3
`define EMB_STB_LAST 4'h9
`define EMB_WDATA_FIRST 4'h2
`define EMB_WDATA_LAST 4'hA
`define EMB_DATA_CAP 4'hB

// internal program memory upper bound
`define EMB_INT_TOP 16'h4000

// one-hot cycle kinds
`define EMB_MODE_INT 3'h1
`define EMB_MODE_FETCH 3'h2
`define EMB_MODE_DATA 3'h4

// reset values and the all-ones enable byte
`define EMB_BYTE_ZERO 8'h00
`define EMB_BYTE_ONES 8'hFF
`define EMB_WORD_ZERO 16'h0000

`endif

// file: emb_bus_port.v
// external program and data memory bus port of an 8-bit controller core
// assumes CLK_SYS_I is the oscillator input; an external latch captures the
// low address on the falling edge of the address latch strobe; pins resolved outside
//
// Summary of operation
// - oscillator divided by two before state clocking
// - upper address byte on high port
// - indirect moves show high latch, weak pull-ups
// - address on high port driven strongly
// - high port quasi-bidirectional, ones pulled up weakly
// - fetch strobe every three periods, not data
// - fetch strobe high during internal execution
// - latch strobe every six periods, not data
// - latch strobe disable when executing internally
// - internal fetch below 4000 hex if selected
// - select low forces all fetches external
// - low port open-drain, ones float
// - low port carries address then data
// - low port drives ones strongly as bus
// - write strobe, memory captures low port
// - read strobe, memory drives low port
`include "emb_bus_map.vh"

module emb_bus_port (
    // clock and reset
    input wire CLK_SYS_I,
    input wire RST_I,
    // core side: fetch and data move requests
    input wire [15:0] PC_I,
    input wire EXT_DATA_RD_I,
    input wire EXT_DATA_WR_I,
    input wire EXT_DATA_USE_PTR_I,
    input wire [15:0] EXT_DATA_ADDR_I,
    input wire [7:0] EXT_DATA_WDATA_I,
    input wire [7:0] HIGH_PORT_LATCH_I,
    input wire [7:0] LOW_PORT_LATCH_I,
    input wire LATCH_STROBE_DISABLE_I,
    // core side: answers
    output reg REQ_TAKE_O,
    output reg FETCH_EXT_O,
    output reg FETCH_DONE_O,
    output reg [7:0] FETCH_DATA_O,
    output reg EXT_DATA_DONE_O,
    output reg [7:0] EXT_DATA_RDATA_O,
    output wire [7:0] LOW_PORT_IN_O,
    output wire [7:0] HIGH_PORT_IN_O,
    // pins: strobes and select
    input wire INTERNAL_PROGRAM_SELECT_I,
    output reg ADDR_LATCH_STROBE_O,
    output reg PROGRAM_FETCH_STROBE_N_O,
    output reg WRITE_STROBE_N_O,
    output reg READ_STROBE_N_O,
    // pins: low port
    input wire [7:0] LOW_PORT_I,
    output reg [7:0] LOW_PORT_O,
    output reg [7:0] LOW_PORT_OE_O,
    // pins: high port
    input wire [7:0] HIGH_PORT_I,
    output reg [7:0] HIGH_PORT_O,
    output reg [7:0] HIGH_PORT_OE_O,
    output reg [7:0] HIGH_PORT_PU_O
);

    // timing state
    reg phase_reg;
    reg [2:0] state_reg;
    reg phase_next;
    reg [2:0] state_next;
    wire [3:0] cnt;
    wire [3:0] cnt_next;

    // cycle context
    reg [2:0] mode_reg;
    reg [15:0] addr_reg;
    reg wr_reg;
    reg ptr_reg;
    reg [7:0] wdata_reg;
    reg [2:0] mode_next;
    reg [15:0] addr_next;
    reg wr_next;
    reg ptr_next;
    reg [7:0] wdata_next;

    // synchronised pins
    wire select_sync;
    wire [7:0] low_sync;
    wire [7:0] high_sync;
    wire fetch_ext;
    wire last;

    // pin next values
    reg ale_next;
    reg pfs_n_next;
    reg wr_n_next;
    reg rd_n_next;
    reg [7:0] low_next;
    reg [7:0] low_oe_next;
    reg [7:0] high_next;
    reg [7:0] high_oe_next;
    reg [7:0] high_pu_next;
    reg ale_win;
    reg ale_win_a;
    reg pfs_slot;
    reg stb_win;
    reg wdata_win;

    emb_sync #(.WIDTH(1)) u_sync_select (
        .clk_i(CLK_SYS_I),
        .rst_i(RST_I),
        .d_i(INTERNAL_PROGRAM_SELECT_I),
        .q_o(select_sync)
    );

    emb_sync #(.WIDTH(8)) u_sync_low (
        .clk_i(CLK_SYS_I),
        .rst_i(RST_I),
        .d_i(LOW_PORT_I),
        .q_o(low_sync)
    );

    emb_sync #(.WIDTH(8)) u_sync_high (
        .clk_i(CLK_SYS_I),
        .rst_i(RST_I),
        .d_i(HIGH_PORT_I),
        .q_o(high_sync)
    );

    assign LOW_PORT_IN_O = low_sync;
    assign HIGH_PORT_IN_O = high_sync;

    always @* begin
        phase_next = ~phase_reg;
        state_next = state_reg;
        if (phase_reg) begin
            if (state_reg == `EMB_STATE_LAST) begin
                state_next = 3'h0;
            end else begin
                state_next = state_reg + 3'h1;
            end
        end
    end

    assign cnt = {state_reg, 1'b0} + {3'h0, phase_reg};
    assign cnt_next = {state_next, 1'b0} + {3'h0, phase_next};
    assign last = (cnt == `EMB_C_LAST);

    assign fetch_ext = ~select_sync | (PC_I >= `EMB_INT_TOP);

    // cycle kind taken at the end of each machine cycle
    always @* begin
        mode_next = mode_reg;
        addr_next = addr_reg;
        wr_next = wr_reg;
        ptr_next = ptr_reg;
        wdata_next = wdata_reg;
        if (last) begin
            wr_next = EXT_DATA_WR_I;
            ptr_next = EXT_DATA_USE_PTR_I;
            wdata_next = EXT_DATA_WDATA_I;
            if (EXT_DATA_RD_I | EXT_DATA_WR_I) begin
                mode_next = `EMB_MODE_DATA;
                addr_next = EXT_DATA_ADDR_I;
            end else if (fetch_ext) begin
                mode_next = `EMB_MODE_FETCH;
                addr_next = PC_I;
            end else begin
                mode_next = `EMB_MODE_INT;
                addr_next = PC_I;
            end
        end
    end

    // pin values for the coming period
    always @* begin
        ale_win_a = (cnt_next == `EMB_ALE_A0) | (cnt_next == `EMB_ALE_A1);
        ale_win = ale_win_a | (cnt_next == `EMB_ALE_B0) | (cnt_next == `EMB_ALE_B1);
        pfs_slot = (cnt_next == `EMB_PFS_0) | (cnt_next == `EMB_PFS_1) |
                   (cnt_next == `EMB_PFS_2) | (cnt_next == `EMB_PFS_3);
        stb_win = (cnt_next >= `EMB_STB_FIRST) & (cnt_next <= `EMB_STB_LAST);
        wdata_win = (cnt_next >= `EMB_WDATA_FIRST) & (cnt_next <= `EMB_WDATA_LAST);
        ale_next = 1'b0;
        pfs_n_next = 1'b1;
        wr_n_next = 1'b1;
        rd_n_next = 1'b1;
        low_next = `EMB_BYTE_ZERO;
        low_oe_next = ~LOW_PORT_LATCH_I;
        high_next = HIGH_PORT_LATCH_I;
        high_oe_next = ~HIGH_PORT_LATCH_I;
        high_pu_next = HIGH_PORT_LATCH_I;
        case (mode_next)
            `EMB_MODE_INT: begin
                ale_next = ale_win & ~LATCH_STROBE_DISABLE_I;
            end
            `EMB_MODE_FETCH: begin
                ale_next = ale_win;
                pfs_n_next = ~pfs_slot;
                high_next = addr_next[15:8];
                high_oe_next = `EMB_BYTE_ONES;
                high_pu_next = `EMB_BYTE_ZERO;
                if (ale_win) begin
                    low_next = addr_next[7:0];
                    low_oe_next = `EMB_BYTE_ONES;
                end else begin
                    low_oe_next = `EMB_BYTE_ZERO;
                end
            end
            `EMB_MODE_DATA: begin
                ale_next = ale_win_a;
                wr_n_next = ~(wr_next & stb_win);
                rd_n_next = ~(~wr_next & stb_win);
                if (ptr_next) begin
                    high_next = addr_next[15:8];
                    high_oe_next = `EMB_BYTE_ONES;
                    high_pu_next = `EMB_BYTE_ZERO;
                end
                if (ale_win_a) begin
                    low_next = addr_next[7:0];
                    low_oe_next = `EMB_BYTE_ONES;
                end else if (wr_next & wdata_win) begin
                    low_next = wdata_next;
                    low_oe_next = `EMB_BYTE_ONES;
                end else begin
                    low_oe_next = `EMB_BYTE_ZERO;
                end
            end
            default: begin
                ale_next = 1'b0;
            end
        endcase
    end

    // timing and context registers
    always @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            phase_reg <= 1'b0;
            state_reg <= 3'h0;
            mode_reg <= `EMB_MODE_INT;
            addr_reg <= `EMB_WORD_ZERO;
            wr_reg <= 1'b0;
            ptr_reg <= 1'b0;
            wdata_reg <= `EMB_BYTE_ZERO;
        end else begin
            phase_reg <= phase_next;
            state_reg <= state_next;
            mode_reg <= mode_next;
            addr_reg <= addr_next;
            wr_reg <= wr_next;
            ptr_reg <= ptr_next;
            wdata_reg <= wdata_next;
        end
    end

    // registered pins
    always @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            ADDR_LATCH_STROBE_O <= 1'b0;
            PROGRAM_FETCH_STROBE_N_O <= 1'b1;
            WRITE_STROBE_N_O <= 1'b1;
            READ_STROBE_N_O <= 1'b1;
            LOW_PORT_O <= `EMB_BYTE_ZERO;
            LOW_PORT_OE_O <= `EMB_BYTE_ZERO;
            HIGH_PORT_O <= `EMB_BYTE_ZERO;
            HIGH_PORT_OE_O <= `EMB_BYTE_ZERO;
            HIGH_PORT_PU_O <= `EMB_BYTE_ZERO;
        end else begin
            ADDR_LATCH_STROBE_O <= ale_next;
            PROGRAM_FETCH_STROBE_N_O <= pfs_n_next;
            WRITE_STROBE_N_O <= wr_n_next;
            READ_STROBE_N_O <= rd_n_next;
            LOW_PORT_O <= low_next;
            LOW_PORT_OE_O <= low_oe_next;
            HIGH_PORT_O <= high_next;
            HIGH_PORT_OE_O <= high_oe_next;
            HIGH_PORT_PU_O <= high_pu_next;
        end
    end

    // core answers
    always @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            REQ_TAKE_O <= 1'b0;
            FETCH_EXT_O <= 1'b0;
            FETCH_DONE_O <= 1'b0;
            FETCH_DATA_O <= `EMB_BYTE_ZERO;
            EXT_DATA_DONE_O <= 1'b0;
            EXT_DATA_RDATA_O <= `EMB_BYTE_ZERO;
        end else begin
            REQ_TAKE_O <= (cnt_next == `EMB_C_LAST);
            FETCH_EXT_O <= (mode_next == `EMB_MODE_FETCH);
            FETCH_DONE_O <= (mode_reg == `EMB_MODE_FETCH) & (cnt == `EMB_FETCH_CAP);
            if ((mode_reg == `EMB_MODE_FETCH) & (cnt == `EMB_FETCH_CAP)) begin
                FETCH_DATA_O <= low_sync;
            end
            EXT_DATA_DONE_O <= (mode_reg == `EMB_MODE_DATA) & (cnt == `EMB_DATA_CAP);
            if ((mode_reg == `EMB_MODE_DATA) & (cnt == `EMB_DATA_CAP) & ~wr_reg) begin
                EXT_DATA_RDATA_O <= low_sync;
            end
        end
    end

endmodule

// file: emb_bus_port_sva.sv
// checker for the external memory bus port pins
// assumes it is bound to emb_bus_port and sees its ports only
module emb_bus_port_sva (
    // clock and reset
    input wire CLK_SYS_I,
    input wire RST_I,
    // strobes and answers
    input wire REQ_TAKE_O,
    input wire FETCH_EXT_O,
    input wire FETCH_DONE_O,
    input wire EXT_DATA_DONE_O,
    input wire ADDR_LATCH_STROBE_O,
    input wire PROGRAM_FETCH_STROBE_N_O,
    input wire WRITE_STROBE_N_O,
    input wire READ_STROBE_N_O,
    // port drivers
    input wire [7:0] LOW_PORT_O,
    input wire [7:0] LOW_PORT_OE_O,
    input wire [7:0] HIGH_PORT_OE_O,
    input wire [7:0] HIGH_PORT_PU_O
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);
    sequence s_take_ale; REQ_TAKE_O ##1 ADDR_LATCH_STROBE_O; endsequence
    sequence s_rd_win; !READ_STROBE_N_O [*7] ##1 READ_STROBE_N_O; endsequence
    sequence s_wr_win; !WRITE_STROBE_N_O [*7] ##1 WRITE_STROBE_N_O; endsequence
    property p_take; REQ_TAKE_O |=> !REQ_TAKE_O [*8] ##1 !REQ_TAKE_O [*3] ##1 REQ_TAKE_O; endproperty
    a_take: assert property (p_take) else $error("machine cycle length wrong");
    property p_ale; s_take_ale |=> ADDR_LATCH_STROBE_O ##1 !ADDR_LATCH_STROBE_O [*4]; endproperty
    a_ale: assert property (p_ale) else $error("latch strobe spacing wrong");
    property p_pfs; FETCH_EXT_O && !PROGRAM_FETCH_STROBE_N_O && !REQ_TAKE_O |=>
        PROGRAM_FETCH_STROBE_N_O [*2] ##1 !PROGRAM_FETCH_STROBE_N_O; endproperty
    a_pfs: assert property (p_pfs) else $error("fetch strobe not every three periods");
    property p_no_pfs; !FETCH_EXT_O |-> PROGRAM_FETCH_STROBE_N_O; endproperty
    a_no_pfs: assert property (p_no_pfs) else $error("fetch strobe outside fetch");
    property p_rd; $fell(READ_STROBE_N_O) |-> s_rd_win and !ADDR_LATCH_STROBE_O [*5]; endproperty
    a_rd: assert property (p_rd) else $error("read strobe window wrong");
    property p_wr; $fell(WRITE_STROBE_N_O) |-> s_wr_win and (LOW_PORT_OE_O == 8'hFF) [*7]; endproperty
    a_wr: assert property (p_wr) else $error("write strobe window wrong");
    property p_addr; $rose(ADDR_LATCH_STROBE_O) && FETCH_EXT_O |-> LOW_PORT_OE_O == 8'hFF
        ##1 (ADDR_LATCH_STROBE_O && $stable(LOW_PORT_O) && LOW_PORT_OE_O == 8'hFF); endproperty
    a_addr: assert property (p_addr) else $error("low address not held under latch strobe");
    property p_high; FETCH_EXT_O |-> HIGH_PORT_OE_O == 8'hFF && HIGH_PORT_PU_O == 8'h00; endproperty
    a_high: assert property (p_high) else $error("high address not driven strongly");
    property p_fdone; FETCH_DONE_O |-> FETCH_EXT_O && !PROGRAM_FETCH_STROBE_N_O ##1 !FETCH_DONE_O; endproperty
    a_fdone: assert property (p_fdone) else $error("fetch done outside fetch strobe");
    property p_ddone; EXT_DATA_DONE_O |-> !($past(READ_STROBE_N_O, 3) && $past(WRITE_STROBE_N_O, 3))
        ##1 !EXT_DATA_DONE_O; endproperty
    a_ddone: assert property (p_ddone) else $error("data done without strobe");
endmodule

bind emb_bus_port emb_bus_port_sva chk (.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .REQ_TAKE_O(REQ_TAKE_O),
    .FETCH_EXT_O(FETCH_EXT_O), .FETCH_DONE_O(FETCH_DONE_O), .EXT_DATA_DONE_O(EXT_DATA_DONE_O),
    .ADDR_LATCH_STROBE_O(ADDR_LATCH_STROBE_O), .PROGRAM_FETCH_STROBE_N_O(PROGRAM_FETCH_STROBE_N_O),
    .WRITE_STROBE_N_O(WRITE_STROBE_N_O), .READ_STROBE_N_O(READ_STROBE_N_O), .LOW_PORT_O(LOW_PORT_O),
    .LOW_PORT_OE_O(LOW_PORT_OE_O), .HIGH_PORT_OE_O(HIGH_PORT_OE_O), .HIGH_PORT_PU_O(HIGH_PORT_PU_O));

// file: emb_bus_port_tb.sv
// self-checking bench for the external memory bus port
// assumes the memory model answers at once; core requests driven by tasks
module emb_bus_port_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst, rd, wr, ptr, dis, dis_set, sel, take, fext, fdone, ddone, ale, pfs_n, wr_n, rd_n;
    logic [15:0] pc, addr, n_ale, n_pfs, n_rd, n_wr, n_fx, h0, hoe, hpu, loe, hin, lin, fb;
    logic [7:0] wdat, hlat, llat, hext, fdat, rdat, lo, lo_oe, hi, hi_oe, hi_pu, lo_pin, hi_pin, hi_in, lo_in;
    int mismatches, total_checks;
    emb_bus_port dut (.CLK_SYS_I(clk), .RST_I(rst), .PC_I(pc), .EXT_DATA_RD_I(rd), .EXT_DATA_WR_I(wr),
        .EXT_DATA_USE_PTR_I(ptr), .EXT_DATA_ADDR_I(addr), .EXT_DATA_WDATA_I(wdat), .HIGH_PORT_LATCH_I(hlat),
        .LOW_PORT_LATCH_I(llat), .LATCH_STROBE_DISABLE_I(dis), .REQ_TAKE_O(take), .FETCH_EXT_O(fext),
        .FETCH_DONE_O(fdone), .FETCH_DATA_O(fdat), .EXT_DATA_DONE_O(ddone), .EXT_DATA_RDATA_O(rdat),
        .LOW_PORT_IN_O(lo_in), .HIGH_PORT_IN_O(hi_in), .INTERNAL_PROGRAM_SELECT_I(sel), .ADDR_LATCH_STROBE_O(ale),
        .PROGRAM_FETCH_STROBE_N_O(pfs_n), .WRITE_STROBE_N_O(wr_n), .READ_STROBE_N_O(rd_n), .LOW_PORT_I(lo_pin),
        .LOW_PORT_O(lo), .LOW_PORT_OE_O(lo_oe), .HIGH_PORT_I(hi_pin), .HIGH_PORT_O(hi), .HIGH_PORT_OE_O(hi_oe),
        .HIGH_PORT_PU_O(hi_pu));
    emb_mem_model mem (.clk_i(clk), .ale_i(ale), .pfs_n_i(pfs_n), .rd_n_i(rd_n), .wr_n_i(wr_n), .lo_i(lo),
        .lo_oe_i(lo_oe), .hi_i(hi), .hi_oe_i(hi_oe), .hi_pu_i(hi_pu), .hi_ext_i(hext), .lo_pin_o(lo_pin),
        .hi_pin_o(hi_pin));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one machine cycle: request at the take edge, then tally the pins
    task automatic run(input logic [15:0] p, input logic r, input logic w, input logic u,
        input logic [15:0] a, input logic [7:0] d);
        int k;
        k = 0;
        while (take !== 1'h1 && k < 30) begin
            @(posedge clk);
            #1 k++;
        end
        chk(16'(k < 30), 16'h1);
        pc = p;
        rd = r;
        wr = w;
        ptr = u;
        addr = a;
        wdat = d;
        dis = dis_set;
        @(posedge clk);
        #1 rd = 1'h0;
        wr = 1'h0;
        {n_ale, n_pfs, n_rd, n_wr, n_fx} = '0;
        for (int c = 0; c < 12; c++) begin
            n_ale += ale;
            n_pfs += !pfs_n;
            n_rd += !rd_n;
            n_wr += !wr_n;
            n_fx += fext;
            if (c == 0) h0 = hi;
            if (c == 4) {hoe, hpu, loe} = {8'h00, hi_oe, 8'h00, hi_pu, 8'h00, lo_oe};
            if (c == 10) {lin, hin} = {8'h00, lo_in, 8'h00, hi_in};
            if (fdone === 1'h1) fb = fdat;
            @(posedge clk);
            #1;
        end
    endtask
    task automatic t_internal;
        sel = 1'h1;
        llat = 8'h0F;
        run(16'h3FFF, 1'h0, 1'h0, 1'h0, 16'h0000, 8'h00);
        chk(n_pfs, 16'h0);
        chk(n_fx, 16'h0);
        chk(n_ale, 16'h4);
        chk(loe, 16'hF0);
        dis_set = 1'h1;
        run(16'h3FFF, 1'h0, 1'h0, 1'h0, 16'h0000, 8'h00);
        run(16'h3FFF, 1'h0, 1'h0, 1'h0, 16'h0000, 8'h00);
        chk(n_ale, 16'h0);
        dis_set = 1'h0;
    endtask
    task automatic t_fetch;
        run(16'h4000, 1'h0, 1'h0, 1'h0, 16'h0000, 8'h00);
        chk(n_fx, 16'hC);
        chk(n_pfs, 16'h4);
        chk(n_ale, 16'h4);
        chk(h0, 16'h40);
        chk(fb, 16'h40 ^ 16'h00 ^ 16'hA5);
        sel = 1'h0;
        run(16'h0123, 1'h0, 1'h0, 1'h0, 16'h0000, 8'h00);
        run(16'h0123, 1'h0, 1'h0, 1'h0, 16'h0000, 8'h00);
        chk(n_fx, 16'hC);
        chk(fb, 16'h01 ^ 16'h23 ^ 16'hA5);
        sel = 1'h1;
    endtask
    task automatic t_data;
        run(16'h0010, 1'h1, 1'h1, 1'h1, 16'h12C3, 8'h96);
        chk(n_wr, 16'h7);
        chk(n_rd, 16'h0);
        chk(n_pfs, 16'h0);
        chk(n_ale, 16'h2);
        chk(h0, 16'h12);
        chk(loe, 16'hFF);
        chk(ddone, 1'h1);
        hlat = 8'hF0;
        hext = 8'h3F;
        run(16'h0010, 1'h1, 1'h0, 1'h0, 16'h00C3, 8'h00);
        chk(n_rd, 16'h7);
        chk(hoe, 16'h0F);
        chk(hpu, 16'hF0);
        chk(hin, 16'h30);
        chk(lin, 16'h96);
        chk(ddone, 1'h1);
        chk(rdat, 16'h96);
    endtask
    task automatic test_done;
        if (mismatches == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    initial begin
        {rst, rd, wr, ptr, dis, sel} = 6'h21;
        {pc, addr, wdat} = 40'h0010000000;
        {hlat, llat, hext} = 24'hFFFFFF;
        dis_set = 1'h0;
        mismatches = 0;
        total_checks = 0;
        repeat (12) @(posedge clk);
        #1 rst = 1'h0;
        t_internal;
        t_fetch;
        t_data;
        test_done;
    end
    initial begin
        #20000;
        mismatches++;
        test_done;
    end
endmodule

// file: emb_mem_model.sv
// external program rom, data ram and address latch on the port pins
// assumes strobes and pin enables come straight from the port
module emb_mem_model (
    // clock
    input wire clk_i,
    // strobes
    input wire ale_i,
    input wire pfs_n_i,
    input wire rd_n_i,
    input wire wr_n_i,
    // port drivers
    input wire [7:0] lo_i,
    input wire [7:0] lo_oe_i,
    input wire [7:0] hi_i,
    input wire [7:0] hi_oe_i,
    input wire [7:0] hi_pu_i,
    input wire [7:0] hi_ext_i,
    // resolved pins
    output logic [7:0] lo_pin_o,
    output logic [7:0] hi_pin_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // pattern mixed into fetched bytes
    localparam logic [7:0] FETCH_KEY = 8'hA5;
    logic [7:0] lat = 8'h00;
    logic [7:0] flt = 8'h55;
    logic [7:0] ram [0:255];
    // released lines toggle every cycle
    always @(posedge clk_i) flt <= ~flt;
    // latch follows low port under strobe
    always @(posedge clk_i) if (ale_i) lat <= lo_pin_o;
    always @(posedge wr_n_i) ram[lat] <= lo_pin_o;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            hi_pin_o[i] = hi_oe_i[i] ? hi_i[i] : hi_pu_i[i] ? hi_ext_i[i] : flt[i];
            lo_pin_o[i] = lo_oe_i[i] ? lo_i[i] : !pfs_n_i ? (hi_pin_o[i] ^ lat[i] ^ FETCH_KEY[i])
                : !rd_n_i ? ram[lat][i] : flt[i];
        end
    end
endmodule

// file: emb_sync.v
// two-flop synchroniser for pin inputs
// assumes the input is asynchronous to clk_i; only the second flop is read
module emb_sync #(
    parameter WIDTH = 8
) (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // data
    input wire [WIDTH-1:0] d_i,
    output wire [WIDTH-1:0] q_o
);

    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] sync_reg;

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_reg <= {WIDTH{1'b0}};
            sync_reg <= {WIDTH{1'b0}};
        end else begin
            meta_reg <= d_i;
            sync_reg <= meta_reg;
        end
    end

    assign q_o = sync_reg;

endmodule
